/* rtl/uem_timeout.sv */
`timescale 1ns/1ps
// completion timeout watchdog for one outstanding inbound read
module uem_timeout
	import uem_pkg::*;
#(
	parameter int CYCLES = 160000
) (
	input  wire logic mclk,
	input  wire logic rst,
	uem_evt_if.timer  evt
);
	uem_ct_state_e     state;
	uem_ct_state_e     next_state;
	logic [31:0]       count;
	logic [31:0]       next_count;
	logic              next_expired;
	logic              expired;

	// ===========================================================
	// timer state
	always_comb begin
		next_state = state;
		next_count = count;
		next_expired = 1'b0;
		case (state)
			UEM_CT_IDLE: begin
				next_count = 32'h0;
				if (evt.start) begin
					next_state = UEM_CT_WAIT;
				end
			end
			UEM_CT_WAIT: begin
				if (evt.done) begin
					next_state = UEM_CT_IDLE;
				end else if (count >= 32'(CYCLES - 1)) begin
					next_state = UEM_CT_EXPIRED;
					next_expired = 1'b1;
				end else begin
					next_count = count + 32'h1;
				end
			end
			UEM_CT_EXPIRED: begin
				// expiry lasts one cycle; the slot goes back to idle whether or not a completion comes
				next_state = UEM_CT_IDLE;
			end
			default: next_state = UEM_CT_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= UEM_CT_IDLE;
			count <= 32'h0;
			expired <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			expired <= next_expired;
		end
	end

	assign evt.expired = expired;
endmodule

/* rtl/uncorrectable_error_status_mask.sv */
`timescale 1ns/1ps
`include "uem_cfg.svh"
// Behaviour
// - set bits read 1; write 1 clears
// - bit 20 on unsupported request, incl hot-plug
// - bit 19 never sets
// - bit 18 on malformed packet, log header
// - bit 17 on receive buffer overflow
// - bit 16 unexpected completion, log header
// - bit 15 on hot-plug completer abort, log
// - bit 14 on read timeout 16-32 ms
// - bit 13 on flow control error
// - bit 12 on poisoned packet, log header
// - bit 4 on link protocol error
// - bit 0 always reads zero
// - masked error sends no message
// - masked error skips header log; status sets
// - masked error keeps first error pointer
// - mask bits sticky read-write, reset zero
// - mask bits 19 and 0 read zero
module uncorrectable_error_status_mask
	import uem_pkg::*;
#(
	parameter int CT_CYCLES = `UEM_CT_CYCLES,
	parameter int HDR_W     = 128
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             auxRst,
	input  wire logic             cfgWrite,
	input  wire logic             cfgRead,
	input  wire logic [11:0]      cfgAddr,
	input  wire logic [31:0]      cfgWdata,
	input  wire logic [3:0]       cfgByteEn,
	output logic      [31:0]      cfgRdata,
	output logic                  cfgRdValid,
	input  wire logic             unsupportedRequest,
	input  wire logic             hotPlugParityUr,
	input  wire logic             malformedPacket,
	input  wire logic             receiveOverflow,
	input  wire logic             completionArrive,
	input  wire logic             requesterIdMatch,
	input  wire logic             tagExpected,
	input  wire logic             hotPlugCompleterAbort,
	input  wire logic             readIssued,
	input  wire logic             readCompleted,
	input  wire logic             flowControlError,
	input  wire logic             poisonedPacket,
	input  wire logic             linkProtocolError,
	input  wire logic [HDR_W-1:0] packetHeader,
	output logic                  errorMessage,
	output logic      [4:0]       errorMessageBit,
	output logic                  headerLogWrite,
	output logic      [HDR_W-1:0] headerLogData,
	output logic                  firstErrorPointerWrite,
	output logic      [4:0]       first_error_pointer
);
	uem_word_t        status;
	uem_word_t        next_status;
	uem_word_t        mask;
	uem_word_t        next_mask;
	uem_word_t        events;
	uem_word_t        unmasked;
	uem_word_t        byteMask;
	uem_word_t        w1c;
	logic             ctExpired;
	logic [4:0]       firstBit;
	logic [31:0]      next_rdata;
	logic             next_rdValid;
	logic             next_msg;
	logic [4:0]       next_msgBit;
	logic             next_logWr;
	logic [HDR_W-1:0] next_logData;
	logic             next_fepWr;
	logic [4:0]       next_fep;

	uem_evt_if ctEvt ();

	// ===========================================================
	// completion timeout watchdog
	assign ctEvt.start = readIssued;
	assign ctEvt.done  = readCompleted;
	assign ctExpired   = ctEvt.expired;

	uem_timeout #(.CYCLES(CT_CYCLES)) ctTimer (
		.mclk (mclk),
		.rst  (rst),
		.evt  (ctEvt.timer)
	);

	// ===========================================================
	// error event vector, one bit per class
	always_comb begin
		events = 32'h0;
		events[`UEM_BIT_UR]   = unsupportedRequest | hotPlugParityUr;
		events[`UEM_BIT_ECRC] = 1'b0;
		events[`UEM_BIT_MTLP] = malformedPacket;
		events[`UEM_BIT_RO]   = receiveOverflow;
		events[`UEM_BIT_UC]   = completionArrive & (~requesterIdMatch | ~tagExpected);
		events[`UEM_BIT_CA]   = hotPlugCompleterAbort;
		events[`UEM_BIT_CT]   = ctExpired;
		events[`UEM_BIT_FCP]  = flowControlError;
		events[`UEM_BIT_PTLP] = poisonedPacket;
		events[`UEM_BIT_DLP]  = linkProtocolError;
		events[`UEM_BIT_TE]   = 1'b0;
		events = events & `UEM_IMPL_MASK;
	end

	// masked errors still set status but report nothing
	assign unmasked = events & ~mask;

	// lowest unmasked bit wins when several classes fire together
	always_comb begin
		firstBit = 5'h0;
		for (int i = 31; i >= 0; i--) begin
			if (unmasked[i]) begin
				firstBit = 5'(i);
			end
		end
	end

	// ===========================================================
	// sticky registers: only the auxiliary reset clears them
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			byteMask[b*8 +: 8] = {8{cfgByteEn[b]}};
		end
		w1c = 32'h0;
		next_mask = mask;
		if (cfgWrite && cfgAddr == `UEM_STATUS_OFFSET) begin
			w1c = cfgWdata & byteMask & `UEM_IMPL_MASK;
		end
		if (cfgWrite && cfgAddr == `UEM_MASK_OFFSET) begin
			next_mask = ((cfgWdata & byteMask) | (mask & ~byteMask)) & `UEM_IMPL_MASK;
		end
		// set wins over a clear in the same cycle
		next_status = ((status & ~w1c) | events) & `UEM_IMPL_MASK;
	end

	always_ff @(posedge mclk) begin
		if (auxRst) begin
			status <= `UEM_STATUS_RESET;
			mask   <= `UEM_MASK_RESET;
		end else begin
			status <= next_status;
			mask   <= next_mask;
		end
	end

	// ===========================================================
	// read path and error reporting outputs
	always_comb begin
		next_rdValid = cfgRead;
		next_rdata   = 32'h0;
		if (cfgRead) begin
			case (cfgAddr)
				`UEM_STATUS_OFFSET: next_rdata = status & `UEM_IMPL_MASK;
				`UEM_MASK_OFFSET:   next_rdata = mask & `UEM_IMPL_MASK;
				default:            next_rdata = 32'h0;
			endcase
		end
		next_msg     = |unmasked;
		next_msgBit  = firstBit;
		// only classes that carry a header reach the log
		next_logWr   = |(unmasked & ((32'h1 << `UEM_BIT_MTLP) | (32'h1 << `UEM_BIT_UC)
			| (32'h1 << `UEM_BIT_CA) | (32'h1 << `UEM_BIT_PTLP)));
		next_logData = next_logWr ? packetHeader : headerLogData;
		next_fepWr   = |unmasked;
		next_fep     = (|unmasked) ? firstBit : first_error_pointer;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfgRdata               <= 32'h0;
			cfgRdValid             <= 1'b0;
			errorMessage           <= 1'b0;
			errorMessageBit        <= 5'h0;
			headerLogWrite         <= 1'b0;
			headerLogData          <= '0;
			firstErrorPointerWrite <= 1'b0;
			first_error_pointer    <= 5'h0;
		end else begin
			cfgRdata               <= next_rdata;
			cfgRdValid             <= next_rdValid;
			errorMessage           <= next_msg;
			errorMessageBit        <= next_msgBit;
			headerLogWrite         <= next_logWr;
			headerLogData          <= next_logData;
			firstErrorPointerWrite <= next_fepWr;
			first_error_pointer    <= next_fep;
		end
	end
endmodule

/* shared/uem_cfg.svh */
`ifndef UEM_CFG_SVH
`define UEM_CFG_SVH
// register byte offsets in configuration space
`define UEM_STATUS_OFFSET   12'h104
`define UEM_MASK_OFFSET     12'h108
`define UEM_HDRLOG_OFFSET   12'h11c
// bit positions of the error classes
`define UEM_BIT_UR          20
`define UEM_BIT_ECRC        19
`define UEM_BIT_MTLP        18
`define UEM_BIT_RO          17
`define UEM_BIT_UC          16
`define UEM_BIT_CA          15
`define UEM_BIT_CT          14
`define UEM_BIT_FCP         13
`define UEM_BIT_PTLP        12
`define UEM_BIT_DLP         4
`define UEM_BIT_TE          0
// implemented (writable) bits of both registers
`define UEM_IMPL_MASK       32'h0017f010
`define UEM_STATUS_RESET    32'h00000000
`define UEM_MASK_RESET      32'h00000000
// completion timeout window, least figure, in ms, and clock rate in Hz
`define UEM_CT_MS           16
`define UEM_CLK_HZ          10000000
`define UEM_CT_CYCLES       ((`UEM_CT_MS * `UEM_CLK_HZ + 999) / 1000)
`endif

/* shared/uem_evt_if.sv */
`timescale 1ns/1ps
interface uem_evt_if;
	logic        start;
	logic        done;
	logic        expired;
	modport timer (input start, input done, output expired);
	modport user  (output start, output done, input expired);
endinterface

/* shared/uem_pkg.sv */
package uem_pkg;
	typedef logic [31:0] uem_word_t;
	typedef enum logic [1:0] {UEM_CT_IDLE, UEM_CT_WAIT, UEM_CT_EXPIRED} uem_ct_state_e;
endpackage

/* sim/uem_checker.sv */
`timescale 1ns/1ps
`include "uem_cfg.svh"
// ====================
// port checker: register answers and error report outputs
module uem_checker #(
	parameter int HDR_W = 128
) (
	input logic             mclk,
	input logic             rst,
	input logic             cfgRead,
	input logic [11:0]      cfgAddr,
	input logic [31:0]      cfgRdata,
	input logic             cfgRdValid,
	input logic [HDR_W-1:0] packetHeader,
	input logic             errorMessage,
	input logic [4:0]       errorMessageBit,
	input logic             headerLogWrite,
	input logic [HDR_W-1:0] headerLogData,
	input logic             firstErrorPointerWrite,
	input logic [4:0]       first_error_pointer
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_read_answer: assert property (cfgRead |=> cfgRdValid)
		else $error("read not answered");
	chk_read_cause: assert property (cfgRdValid |-> $past(cfgRead))
		else $error("answer without read");
	chk_unmapped_zero: assert property (cfgRead
		&& !(cfgAddr inside {12'h104, 12'h108}) |=> cfgRdata == 32'h0)
		else $error("unmapped read not zero");
	chk_reserved_zero: assert property (cfgRdValid |-> (cfgRdata & ~`UEM_IMPL_MASK) == 0)
		else $error("unused bit reads one");
	chk_msg_class: assert property (errorMessage |-> errorMessageBit inside
		{5'd20, 5'd18, 5'd17, 5'd16, 5'd15, 5'd14, 5'd13, 5'd12, 5'd4}) else $error("bad class");
	chk_hdr_msg: assert property (headerLogWrite |-> errorMessage)
		else $error("header logged for masked error");
	chk_hdr_data: assert property (headerLogWrite |-> headerLogData == $past(packetHeader))
		else $error("wrong header logged");
	chk_ptr_msg: assert property (firstErrorPointerWrite
		|-> errorMessage && first_error_pointer == errorMessageBit) else $error("bad pointer");
	cover property (headerLogWrite);
	cover property (errorMessage && errorMessageBit == 5'd14);
	cover property (cfgRdValid && cfgRdata != 32'h0);
endmodule
bind uncorrectable_error_status_mask uem_checker #(.HDR_W(HDR_W)) chk (.mclk, .rst, .cfgRead,
	.cfgAddr, .cfgRdata, .cfgRdValid, .packetHeader, .errorMessage, .errorMessageBit,
	.headerLogWrite, .headerLogData, .firstErrorPointerWrite, .first_error_pointer);

/* sim/uem_host_model.sv */
`timescale 1ns/1ps
// host bridge side: takes every error message the port sends up
module uem_host_model (
	input  logic       mclk,
	input  logic       errorMessage,
	input  logic [4:0] errorMessageBit,
	output int         msgCount,
	output logic [4:0] lastBit
);
	// count messages and keep the last class, so masking shows as silence
	initial msgCount = 0;
	always @(posedge mclk)
		if (errorMessage === 1'b1) begin
			msgCount <= msgCount + 1;
			lastBit <= errorMessageBit;
		end
endmodule

/* sim/uncorrectable_error_status_mask_test.sv */
`timescale 1ns/1ps
`include "uem_cfg.svh"
// reads leave a note in a queue; the monitor below checks answers against it
module uncorrectable_error_status_mask_test
	import uem_pkg::*;
;
	logic mclk = 0, rst = 1, auxRst = 1, cfgWrite = 0, cfgRead = 0, readIssued = 0;
	logic readDone = 0, idMatch = 0, tagOk = 1;
	logic [11:0] cfgAddr = 0;
	logic [3:0] cfgByteEn = 4'hf;
	logic [8:0] ev = 0;
	logic [127:0] packetHeader = 0, headerLogData;
	uem_word_t cfgWdata = 0, cfgRdata, w, q[$];
	logic cfgRdValid, errorMessage, headerLogWrite, firstErrorPointerWrite;
	logic [4:0] errorMessageBit, lastBit, first_error_pointer;
	int msgCount, errors = 0, n_checks = 0;
	integer seed = 32'h8556;
	int bt[9] = '{20, 20, 18, 17, 16, 15, 13, 12, 4};
	always #50 mclk = ~mclk;
	uncorrectable_error_status_mask #(.CT_CYCLES(20)) dut (.mclk, .rst, .auxRst, .cfgWrite,
		.cfgRead, .cfgAddr, .cfgWdata, .cfgByteEn, .cfgRdata, .cfgRdValid,
		.unsupportedRequest(ev[0]), .hotPlugParityUr(ev[1]), .malformedPacket(ev[2]),
		.receiveOverflow(ev[3]), .completionArrive(ev[4]), .requesterIdMatch(idMatch),
		.tagExpected(tagOk), .hotPlugCompleterAbort(ev[5]), .readIssued,
		.readCompleted(readDone),
		.flowControlError(ev[6]), .poisonedPacket(ev[7]), .linkProtocolError(ev[8]),
		.packetHeader, .errorMessage, .errorMessageBit, .headerLogWrite, .headerLogData,
		.firstErrorPointerWrite, .first_error_pointer);
	uem_host_model host (.mclk, .errorMessage, .errorMessageBit, .msgCount, .lastBit);
	// inputs move just after the edge, never on it
	task automatic cyc(int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(string nm, uem_word_t s, uem_word_t e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// idle cycle after each strobe so no signal is set twice in one step
	task automatic wr(logic [11:0] a, uem_word_t d, logic [3:0] b = 4'hf);
		{cfgAddr, cfgWdata, cfgByteEn, cfgWrite} = {a, d, b, 1'b1};
		cyc();
		cfgWrite = 0;
		cyc();
	endtask
	task automatic rd(logic [11:0] a, uem_word_t e);
		q.push_back(e);
		{cfgAddr, cfgRead} = {a, 1'b1};
		cyc();
		cfgRead = 0;
		cyc();
	endtask
	// one error pulse; report outputs are looked at in the cycle they stand
	task automatic hit(int i, logic on = 0);
		logic hdr;
		hdr = on && bt[i] inside {18, 16, 15, 12};
		packetHeader = {$random(seed), $random(seed), $random(seed), $random(seed)};
		ev[i] = 1;
		cyc();
		ev = 0;
		chk("errorMessage", errorMessage, on);
		chk("headerLogWrite", headerLogWrite, hdr);
		chk("headerLogData", 32'(hdr ? headerLogData === packetHeader : 1'b1), 1);
		chk("firstErrorPointerWrite", firstErrorPointerWrite, on);
		if (on) chk("first_error_pointer", first_error_pointer, bt[i]);
		cyc();
	endtask
	// without an answer the watchdog has to run out; an early answer stops it
	task automatic lapse(logic answer = 0);
		readIssued = 1;
		cyc();
		{readIssued, readDone} = {1'b0, answer};
		cyc();
		readDone = 0;
		cyc(23);
	endtask
	always @(posedge mclk)
		if (cfgRdValid === 1'b1) begin
			if (q.size() == 0) chk("spare answer", 1, 0);
			else chk("cfgRdata", cfgRdata, q.pop_front());
		end
	initial begin
		cyc(10);
		{rst, auxRst} = 0;
		cyc();
		rd(12'h104, 0);
		rd(12'h10c, 0);
		wr(12'h108, 32'hffffffff, 4'h1);
		rd(12'h108, 32'h00000010);
		wr(12'h108, 32'hffffffff);
		rd(12'h108, `UEM_IMPL_MASK);
		// all masked: status still sets but the host hears nothing
		for (int i = 0; i < 9; i++) hit(i);
		lapse();
		rd(12'h104, `UEM_IMPL_MASK);
		chk("msgCount", msgCount, 0);
		wr(12'h104, 0);
		rd(12'h104, `UEM_IMPL_MASK);
		wr(12'h104, 32'hffffffff, 4'h4);
		rd(12'h104, 32'h0000f010);
		w = $random(seed);
		wr(12'h104, w);
		rd(12'h104, 32'h0000f010 & ~w);
		wr(12'h104, 32'hffffffff);
		rd(12'h104, 0);
		$display("test masked done");
		wr(12'h108, 0);
		for (int i = 0; i < 9; i++) begin
			hit(i, 1);
			chk("lastBit", lastBit, bt[i]);
			rd(12'h104, 32'h1 << bt[i]);
			wr(12'h104, 32'h1 << bt[i]);
		end
		// id and tag both expected is no error; a stray tag is
		{idMatch, ev[4]} = 2'b11;
		cyc();
		{tagOk, ev[4]} = 2'b01;
		cyc();
		{idMatch, tagOk, ev[4]} = 3'b010;
		cyc();
		rd(12'h104, 32'h00010000);
		wr(12'h104, 32'h00010000);
		// bit 4 masked, so the pointer goes to the other class of the pair
		wr(12'h108, 32'h00000010);
		{ev[2], ev[8]} = 2'b11;
		cyc();
		ev = 0;
		chk("first_error_pointer", first_error_pointer, 18);
		chk("errorMessageBit", errorMessageBit, 18);
		cyc();
		rd(12'h104, 32'h00040010);
		wr(12'h104, 32'h00040010);
		wr(12'h108, 0);
		lapse(1);
		chk("msgCount", msgCount, 11);
		lapse();
		chk("lastBit", lastBit, 14);
		chk("msgCount", msgCount, 12);
		$display("test unmasked done");
		wr(12'h108, 32'h00001000);
		rst = 1;
		cyc(10);
		rst = 0;
		cyc();
		rd(12'h104, 32'h00004000);
		rd(12'h108, 32'h00001000);
		auxRst = 1;
		cyc();
		auxRst = 0;
		rd(12'h104, 0);
		$display("test sticky done");
		chk("pending reads", q.size(), 0);
		test_done;
	end
	initial begin
		cyc(5000);
		errors++;
		test_done;
	end
endmodule
